// *** core/mefr_core.sv ***
// Fault classifier, fault registers and trap/interrupt/ack generation
`default_nettype none
// Function
// - Fetch parity error: type 5, fetch error trap
// - CPU read parity: memory status, level15
// - Fetch walk parity: type 4, fetch trap
// - Data walk parity: type 4, address, trap
// - DMA parity: error ack, status, level15
// - CPU read timeout: type 5, data trap
// - CPU write timeout: async status, level15
// - DMA timeout/invalid/readonly get error ack
// - Late error sets async late status
// - CPU read error ack: type 5 trap
// - CPU write error ack: async, level15
// - Entry type 0: fault type 1 exception
// - Entry type 3: fault type 4 error
// - Bad alternate space: type 5 control
// - Supervisor fetch violation: type 3 exception
// - Data privilege fail: type 3 exception
// - Data permission fail: type 2 exception
// - Decode only six identifier bits
module mefr_core #(
   parameter int AW = 32
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Error event inputs, same clock domain, one-cycle strobes
   input wire logic ev_valid,
   input wire logic ev_fetch,
   input wire logic ev_dma,
   input wire logic ev_write,
   input wire logic ev_walk,
   input wire logic ev_rmw,
   input wire logic ev_parity,
   input wire logic ev_timeout,
   input wire logic ev_late,
   input wire logic ev_bus_err,
   input wire logic ev_pte_bad,
   input wire logic ev_ro_write,
   input wire logic ev_et_valid,
   input wire logic [1:0] entry_type_code,
   input wire logic ev_super_page,
   input wire logic [2:0] page_permission_code,
   input wire logic ev_priv_fail,
   input wire logic ev_prot_fail,
   input wire logic ev_alt,
   input wire logic [7:0] ev_asi,
   input wire logic ev_asi_ok,
   input wire logic ev_size_ok,
   input wire logic ev_va_ok,
   input wire logic [1:0] ev_size,
   input wire logic [1:0] ev_level,
   input wire logic [2:0] access_type_code,
   input wire logic [AW-1:0] data_virtual_address,
   input wire logic [AW-1:0] ev_pa,
   // Trap, interrupt and bus answers
   output logic inst_access_error,
   output logic inst_access_exc,
   output logic data_access_error,
   output logic data_access_exc,
   output logic level15_interrupt,
   output logic dma_error_ack,
   output logic [5:0] asi_decoded
);
   if (AW < 8 || AW > 32) begin : g_aw_check
      $error("AW must be 8..32");
   end

   logic [14:0] sync_fault_status_q;
   logic [AW-1:0] sync_fault_address_q;
   logic [4:0] memory_fault_status_q;
   logic [AW-1:0] memory_fault_address_q;
   logic [7:0] async_fault_status_q;
   logic [AW-1:0] async_fault_address_q;
   logic l15_en_q;
   logic l15_pend_q;

   // ---------------------------------------------------------------
   // Classification
   // ---------------------------------------------------------------
   logic cpu, et_inv, et_res, asi_bad, sup_viol;
   logic fetch_par, fwalk_par, dwalk_par, mem_par, dma_par;
   logic rd_to, wr_to, rd_be, wr_be, late, dma_ack;
   logic et0_f, et0_d, et3_f, et3_d, priv_d, prot_d;
   logic sync_hit, mem_hit, async_hit;
   logic [2:0] ft;
   logic favs, css;

   assign cpu = ev_valid && !ev_dma;
   assign asi_decoded = ev_asi[mefr_pkg::ASI_BITS-1:0];
   assign asi_bad = ev_alt && !(ev_asi_ok && ev_size_ok && ev_va_ok);
   assign et_inv = ev_et_valid && entry_type_code == mefr_pkg::ET_INVALID;
   assign et_res = ev_et_valid && entry_type_code == mefr_pkg::ET_RESERVED;
   assign sup_viol = ev_super_page &&
      page_permission_code != mefr_pkg::ACC_SUP_LO &&
      page_permission_code != mefr_pkg::ACC_SUP_HI;

   assign fetch_par = cpu && ev_fetch && ev_parity && !ev_walk;
   assign fwalk_par = cpu && ev_fetch && ev_parity && ev_walk;
   assign dwalk_par = cpu && !ev_fetch && ev_parity && ev_walk;
   assign mem_par = cpu && !ev_fetch && ev_parity && !ev_walk &&
      (!ev_write || ev_rmw);
   assign dma_par = ev_valid && ev_dma && ev_parity &&
      (!ev_write || ev_rmw || ev_walk);
   assign rd_to = cpu && ev_timeout && !ev_write;
   assign wr_to = cpu && ev_timeout && ev_write;
   assign rd_be = cpu && ev_bus_err && !ev_write;
   assign wr_be = cpu && ev_bus_err && ev_write;
   assign late = cpu && ev_late;
   assign et0_f = cpu && ev_fetch && et_inv;
   assign et0_d = cpu && !ev_fetch && et_inv;
   assign et3_f = cpu && ev_fetch && et_res;
   assign et3_d = cpu && !ev_fetch && et_res;
   assign priv_d = cpu && !ev_fetch && ev_priv_fail;
   assign prot_d = cpu && !ev_fetch && ev_prot_fail;
   assign dma_ack = ev_valid && ev_dma &&
      (dma_par || ev_timeout || ev_pte_bad || ev_ro_write);

   // Priority: fetch parity and read timeout/bus faults first, then walk parity and translation, then access
   always_comb begin
      ft = '0;
      favs = 1'b0;
      css = 1'b0;
      sync_hit = 1'b1;
      if (fetch_par || rd_to || rd_be) begin
         ft = mefr_pkg::FT_ACCESS;
         favs = rd_to || rd_be;
      end else if (fwalk_par || dwalk_par || et3_f || et3_d) begin
         ft = mefr_pkg::FT_XLATE;
         favs = dwalk_par || et3_d;
      end else if (et0_f || et0_d) begin
         ft = mefr_pkg::FT_INVALID;
         favs = et0_d;
      end else if (cpu && !ev_fetch && asi_bad) begin
         ft = mefr_pkg::FT_ACCESS;
         favs = 1'b1;
         css = 1'b1;
      end else if (cpu && ev_fetch && sup_viol) begin
         ft = mefr_pkg::FT_PRIV;
      end else if (priv_d) begin
         ft = mefr_pkg::FT_PRIV;
         favs = 1'b1;
      end else if (prot_d) begin
         ft = mefr_pkg::FT_PROT;
         favs = 1'b1;
      end else begin
         sync_hit = 1'b0;
      end
   end

   assign mem_hit = mem_par || dma_par;
   assign async_hit = wr_to || wr_be || late;

   // ---------------------------------------------------------------
   // Register read and capture lock
   // ---------------------------------------------------------------
   logic rd_acc, wr_acc;
   logic rd_sfs, rd_mfs, rd_afs;
   assign rd_acc = psel && penable && !pwrite;
   assign wr_acc = psel && penable && pwrite;
   assign rd_sfs = rd_acc && paddr == mefr_pkg::OFF_SFS;
   assign rd_mfs = rd_acc && paddr == mefr_pkg::OFF_MFS;
   assign rd_afs = rd_acc && paddr == mefr_pkg::OFF_AFS;

   // Records are locked once captured; reading status unlocks them.
   // Later faults are dropped meanwhile so the handler sees one event.
   // A fault in the unlocking read cycle is kept: the read takes the old.
   logic sync_lock_q, mem_lock_q, async_lock_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_lock_q <= 1'b0;
         sync_fault_status_q <= '0;
         sync_fault_address_q <= '0;
      end else if (sync_hit && (!sync_lock_q || rd_sfs)) begin
         sync_lock_q <= 1'b1;
         sync_fault_status_q <= '0;
         sync_fault_status_q[mefr_pkg::SF_FT +: 3] <= ft;
         sync_fault_status_q[mefr_pkg::SF_AT +: 3] <= access_type_code;
         sync_fault_status_q[mefr_pkg::SF_L +: 2] <= ev_level;
         sync_fault_status_q[mefr_pkg::SF_FAV] <= favs;
         sync_fault_status_q[mefr_pkg::SF_CS] <= css;
         sync_fault_status_q[mefr_pkg::SF_BE] <= rd_be;
         sync_fault_status_q[mefr_pkg::SF_TO] <= rd_to;
         sync_fault_status_q[mefr_pkg::SF_PE] <= ev_parity;
         if (favs) begin
            sync_fault_address_q <= data_virtual_address;
         end
      end else if (rd_sfs) begin
         sync_lock_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_lock_q <= 1'b0;
         memory_fault_status_q <= '0;
         memory_fault_address_q <= '0;
      end else if (mem_hit && (!mem_lock_q || rd_mfs)) begin
         mem_lock_q <= 1'b1;
         memory_fault_status_q[mefr_pkg::MF_ERR] <= 1'b1;
         memory_fault_status_q[mefr_pkg::MF_PE] <= 1'b1;
         memory_fault_status_q[mefr_pkg::MF_CP] <= mem_par;
         memory_fault_status_q[mefr_pkg::MF_TYPE +: 2] <=
            {ev_rmw, ev_write};
         memory_fault_address_q <= ev_pa;
      end else if (rd_mfs) begin
         mem_lock_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_lock_q <= 1'b0;
         async_fault_status_q <= '0;
         async_fault_address_q <= '0;
      end else if (async_hit && (!async_lock_q || rd_afs)) begin
         async_lock_q <= 1'b1;
         async_fault_status_q[mefr_pkg::AF_ERR] <= 1'b1;
         async_fault_status_q[mefr_pkg::AF_TO] <= wr_to;
         async_fault_status_q[mefr_pkg::AF_LE] <= late;
         async_fault_status_q[mefr_pkg::AF_BE] <= wr_be;
         async_fault_status_q[mefr_pkg::AF_RD] <= !ev_write;
         // Late write errors only flag the address when it is known
         async_fault_status_q[mefr_pkg::AF_FAV] <= !ev_write ||
            !late || ev_va_ok;
         async_fault_status_q[mefr_pkg::AF_SIZE +: 2] <= ev_size;
         async_fault_address_q <= ev_pa;
      end else if (rd_afs) begin
         async_lock_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Traps and level15 interrupt (processor status path)
   // ---------------------------------------------------------------
   logic fetch_err_d, fetch_err_q;
   assign fetch_err_d = fwalk_par || et3_f;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_err_q <= 1'b0;
         inst_access_error <= 1'b0;
         inst_access_exc <= 1'b0;
         data_access_error <= 1'b0;
         data_access_exc <= 1'b0;
         dma_error_ack <= 1'b0;
      end else begin
         // Walk faults trap at decode; plain fetch parity one stage later
         fetch_err_q <= fetch_par;
         inst_access_error <= fetch_err_d || fetch_err_q;
         inst_access_exc <= et0_f ||
            (cpu && ev_fetch && sup_viol);
         data_access_error <= dwalk_par || rd_to || rd_be || et3_d;
         data_access_exc <= et0_d || priv_d || prot_d ||
            (cpu && !ev_fetch && asi_bad);
         dma_error_ack <= dma_ack;
      end
   end

   // DMA parity counts here too, beside CPU memory parity and CPU write timeout/bus error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l15_pend_q <= 1'b0;
      end else if (mem_hit || wr_to || wr_be) begin
         l15_pend_q <= 1'b1;
      end else if (rd_mfs || rd_afs) begin
         l15_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l15_en_q <= 1'b1;
      end else if (wr_acc && paddr == mefr_pkg::OFF_CTL) begin
         l15_en_q <= pwdata[0];
      end
   end

   assign level15_interrupt = l15_pend_q && l15_en_q;

   // ---------------------------------------------------------------
   // APB read mux
   // ---------------------------------------------------------------
   logic known;
   always_comb begin
      known = 1'b1;
      unique case (paddr)
         mefr_pkg::OFF_SFS: prdata = 32'(sync_fault_status_q);
         mefr_pkg::OFF_SFA: prdata = 32'(sync_fault_address_q);
         mefr_pkg::OFF_MFS: prdata = 32'(memory_fault_status_q);
         mefr_pkg::OFF_MFA: prdata = 32'(memory_fault_address_q);
         mefr_pkg::OFF_AFS: prdata = 32'(async_fault_status_q);
         mefr_pkg::OFF_AFA: prdata = 32'(async_fault_address_q);
         mefr_pkg::OFF_CTL: prdata = {31'h0, l15_en_q};
         default: begin
            prdata = 32'h0;
            known = 1'b0;
         end
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !known;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_fetch_par_delay: assert property (@(posedge pclk) disable iff (!presetn)
      fetch_par |-> ##2 inst_access_error)
      else $error("fetch parity trap not two cycles later");
   chk_dma_ack_out: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_valid && ev_dma && ev_ro_write) |=> dma_error_ack)
      else $error("dma error ack missing");
   chk_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_lock_q && !rd_sfs) |=> $stable(sync_fault_status_q))
      else $error("sync status changed while locked");
   chk_l15_raise: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_to && l15_en_q) |=> level15_interrupt)
      else $error("level15 not raised");
   chk_data_err_trap: assert property (@(posedge pclk) disable iff (!presetn)
      rd_be |=> data_access_error)
      else $error("data error trap missing");
   chk_et0_code: assert property (@(posedge pclk) disable iff (!presetn)
      (et0_d && !sync_lock_q && !fetch_par && !rd_to && !rd_be
       && !dwalk_par) |=>
      sync_fault_status_q[mefr_pkg::SF_FT +: 3] == mefr_pkg::FT_INVALID)
      else $error("entry type 0 code wrong");
   chk_exc_trap: assert property (@(posedge pclk) disable iff (!presetn)
      (priv_d || prot_d) |=> data_access_exc)
      else $error("data exception missing");
   chk_mem_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_par && !mem_lock_q) |=> memory_fault_address_q == $past(ev_pa))
      else $error("memory fault address not stored");
endmodule : mefr_core
`default_nettype wire

// *** core/mefr_pkg.sv ***
// Package: constants for the memory error fault reporter
`default_nettype none
package mefr_pkg;
   // Fault type codes
   localparam logic [2:0] FT_INVALID = 3'h1;
   localparam logic [2:0] FT_PROT = 3'h2;
   localparam logic [2:0] FT_PRIV = 3'h3;
   localparam logic [2:0] FT_XLATE = 3'h4;
   localparam logic [2:0] FT_ACCESS = 3'h5;
   // Entry type codes and permission codes
   localparam logic [1:0] ET_INVALID = 2'h0;
   localparam logic [1:0] ET_RESERVED = 2'h3;
   localparam logic [2:0] ACC_SUP_LO = 3'h6;
   localparam logic [2:0] ACC_SUP_HI = 3'h7;
   // Identifier bits decoded
   localparam int ASI_BITS = 6;
   // Register offsets (APB byte addresses)
   localparam logic [7:0] OFF_SFS = 8'h00;
   localparam logic [7:0] OFF_SFA = 8'h04;
   localparam logic [7:0] OFF_MFS = 8'h08;
   localparam logic [7:0] OFF_MFA = 8'h0C;
   localparam logic [7:0] OFF_AFS = 8'h10;
   localparam logic [7:0] OFF_AFA = 8'h14;
   localparam logic [7:0] OFF_CTL = 8'h18;
   // Sync status fields
   localparam int SF_FT = 2;     // [4:2]
   localparam int SF_AT = 5;     // [7:5]
   localparam int SF_L = 8;      // [9:8]
   localparam int SF_FAV = 10;
   localparam int SF_CS = 11;
   localparam int SF_BE = 12;
   localparam int SF_TO = 13;
   localparam int SF_PE = 14;
   // Memory/async status fields
   localparam int MF_ERR = 0;
   localparam int MF_PE = 1;
   localparam int MF_CP = 2;
   localparam int MF_TYPE = 3;   // [4:3]
   localparam int AF_ERR = 0;
   localparam int AF_TO = 1;
   localparam int AF_LE = 2;
   localparam int AF_BE = 3;
   localparam int AF_RD = 4;
   localparam int AF_FAV = 5;
   localparam int AF_SIZE = 6;   // [7:6]
endpackage : mefr_pkg
`default_nettype wire

// *** verification/mefr_evt_src.sv ***
// Model of the pipeline and bus masters that report fault events
`default_nettype none
module mefr_evt_src #(
   parameter logic [31:0] VA = 32'hA000_1234,
   parameter logic [31:0] PA = 32'h0004_5678
) (
   // Strobe and kind flags
   output logic ev_valid,
   output logic [15:0] flags,
   output logic [2:0] oks,
   // Walk and page attributes
   output logic [1:0] etype,
   output logic [2:0] perm,
   output logic [1:0] lvl,
   output logic [2:0] acode,
   output logic [7:0] asi,
   // Addresses
   output logic [31:0] va,
   output logic [31:0] pa
);
   // ----------
   // Event launch
   // ----------
   // Called just after a rising edge; strobe lasts one cycle
   task automatic send(input logic [15:0] f, input logic [2:0] k,
      input logic [1:0] e, input logic [2:0] c, input logic [1:0] l,
      input logic [2:0] a);
      ev_valid <= 1'b1;
      flags <= f;
      oks <= k;
      etype <= e;
      perm <= c;
      lvl <= l;
      acode <= a;
      asi <= 8'hE5;
      va <= VA;
      pa <= PA;
   endtask : send
   // Addresses are meaningless off the strobe, so never leave them valid
   task automatic idle;
      ev_valid <= 1'b0;
      asi <= 8'h1A;
      va <= ~VA;
      pa <= ~PA;
   endtask : idle
   // Own master errors go out over the system interrupt, never here
   initial begin
      flags <= 16'h0000;
      oks <= 3'h7;
      etype <= 2'h0;
      perm <= 3'h0;
      lvl <= 2'h0;
      acode <= 3'h0;
      idle();
   end
endmodule : mefr_evt_src
`default_nettype wire

// *** verification/tb_memory_error_fault_reporter.sv ***
// Self-checking bench for the memory error fault reporter
`default_nettype none
module tb_memory_error_fault_reporter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] VA = 32'hA000_1234;
   localparam logic [31:0] PA = 32'h0004_5678;
   localparam logic [15:0] M_FETCH = 16'h0001, M_DMA = 16'h0002,
      M_WR = 16'h0004, M_WALK = 16'h0008, M_RMW = 16'h0010, M_PAR = 16'h0020,
      M_TMO = 16'h0040, M_LATE = 16'h0080, M_BERR = 16'h0100,
      M_PTE = 16'h0200, M_RO = 16'h0400, M_ETV = 16'h0800,
      M_SUP = 16'h1000, M_PRIV = 16'h2000, M_PROT = 16'h4000,
      M_ALT = 16'h8000;
   // Pulses: [9:5] first cycle, [4:0] second, [10] interrupt level
   localparam logic [10:0] NONE = 11'h000, IRQ = 11'h400,
      IAE1 = 11'h200, IAX1 = 11'h100, DAE1 = 11'h080, DAX1 = 11'h040,
      ACK1 = 11'h020, IAE2 = 11'h010;
   localparam logic [4:0] S_PAR = 5'h10, S_TMO = 5'h08, S_BERR = 5'h04,
      S_CTL = 5'h02, S_AV = 5'h01;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, asi;
   logic [31:0] pwdata, prdata, va, pa, r;
   logic ev_valid, iae, iax, dae, dax, l15, dack;
   logic [15:0] flags;
   logic [2:0] oks, perm, acode, g_k, g_c, g_a;
   logic [1:0] etype, lvl, g_e, g_l;
   logic [5:0] asi_dec;
   int num_errors, comparisons;

   mefr_evt_src #(.VA(VA), .PA(PA)) pm (.ev_valid(ev_valid),
      .flags(flags), .oks(oks), .etype(etype), .perm(perm), .lvl(lvl),
      .acode(acode), .asi(asi), .va(va), .pa(pa));
   mefr_core #(.AW(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ev_valid(ev_valid), .ev_fetch(flags[0]), .ev_dma(flags[1]),
      .ev_write(flags[2]), .ev_walk(flags[3]), .ev_rmw(flags[4]),
      .ev_parity(flags[5]), .ev_timeout(flags[6]), .ev_late(flags[7]),
      .ev_bus_err(flags[8]), .ev_pte_bad(flags[9]),
      .ev_ro_write(flags[10]), .ev_et_valid(flags[11]),
      .entry_type_code(etype), .ev_super_page(flags[12]),
      .page_permission_code(perm), .ev_priv_fail(flags[13]),
      .ev_prot_fail(flags[14]), .ev_alt(flags[15]), .ev_asi(asi),
      .ev_asi_ok(oks[2]), .ev_size_ok(oks[1]), .ev_va_ok(oks[0]),
      .ev_size(etype), .ev_level(lvl), .access_type_code(acode),
      .data_virtual_address(va), .ev_pa(pa), .inst_access_error(iae),
      .inst_access_exc(iax), .data_access_error(dae),
      .data_access_exc(dax), .level15_interrupt(l15),
      .dma_error_ack(dack), .asi_decoded(asi_dec));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ----------
   // Access and compare tasks
   // ----------
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         num_errors++;
         $display("Error at %0t: got %h exp %h", $time, g, x);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd_q, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         results();
      end
      rd_q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic irq(input logic x);
      #1;
      chk({31'h0, l15}, {31'h0, x});
   endtask : irq

   function automatic logic [31:0] sf(input logic [2:0] t,
      input logic [4:0] g);
      return {17'h0, g, g_l, g_a, t, 2'h0};
   endfunction : sf

   // Trap pulses are one cycle wide, so both cycles are looked at
   task automatic fire(input logic [15:0] f, input logic [10:0] x,
      input logic cp);
      logic [10:0] p;
      @(posedge pclk);
      pm.send(f, g_k, g_e, g_c, g_l, g_a);
      #1;
      chk({26'h0, asi_dec}, 32'h0000_0025);
      @(posedge pclk);
      pm.idle();
      #1;
      p[9:5] = {iae, iax, dae, dax, dack};
      @(posedge pclk);
      #1;
      p[4:0] = {iae, iax, dae, dax, dack};
      p[10] = l15;
      if (cp) chk({21'h0, p}, {21'h0, x});
   endtask : fire

   task automatic sc(input logic [15:0] f, input logic [10:0] x,
      input logic [31:0] s, input logic v);
      fire(f, x, 1'b1);
      rd(mefr_pkg::OFF_SFS, s);
      if (v) rd(mefr_pkg::OFF_SFA, VA);
   endtask : sc

   initial begin
      num_errors = 0;
      comparisons = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {g_k, g_e, g_c, g_l, g_a} = {3'h7, 2'h0, 3'h0, 2'h2, 3'h3};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(mefr_pkg::OFF_CTL, 32'h1);
      rd(mefr_pkg::OFF_SFS, 32'h0);
      wr(mefr_pkg::OFF_SFS, 32'hFFFF_FFFF);
      rd(mefr_pkg::OFF_SFS, 32'h0);
      apb(1'b0, 8'h1C, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      sc(M_FETCH | M_PAR, IAE2, sf(3'h5, S_PAR), 1'b0);
      sc(M_FETCH | M_WALK | M_PAR, IAE1, sf(3'h4, S_PAR), 1'b0);
      sc(M_WALK | M_PAR, DAE1, sf(3'h4, S_PAR | S_AV), 1'b1);
      sc(M_FETCH | M_WALK | M_ETV, IAX1, sf(3'h1, 5'h0), 1'b0);
      sc(M_WALK | M_ETV, DAX1, sf(3'h1, S_AV), 1'b1);
      g_e = 2'h3;
      sc(M_FETCH | M_WALK | M_ETV, IAE1, sf(3'h4, 5'h0), 1'b0);
      sc(M_WALK | M_ETV, DAE1, sf(3'h4, S_AV), 1'b1);
      g_c = 3'h5;
      sc(M_FETCH | M_SUP, IAX1, sf(3'h3, 5'h0), 1'b0);
      for (int i = 6; i < 8; i++) begin
         g_c = i[2:0];
         fire(M_FETCH | M_SUP, NONE, 1'b1);
      end
      sc(M_PROT, DAX1, sf(3'h2, S_AV), 1'b1);
      g_a = 3'h0;
      for (int i = 0; i < 3; i++) begin
         g_k = 3'h7 ^ (3'h1 << i);
         sc(M_ALT, DAX1, sf(3'h5, S_CTL | S_AV), 1'b1);
      end
      g_k = 3'h7;
      g_l = 2'h0;
      sc(M_TMO, DAE1, sf(3'h5, S_TMO | S_AV), 1'b1);
      sc(M_BERR, DAE1, sf(3'h5, S_BERR | S_AV), 1'b1);
      fire(M_TMO, DAE1, 1'b1);
      sc(M_PRIV, DAX1, sf(3'h5, S_TMO | S_AV), 1'b1);
      g_a = 3'h3;
      sc(M_PRIV, DAX1, sf(3'h3, S_AV), 1'b1);
      fire(M_PAR, IRQ, 1'b1);
      rd(mefr_pkg::OFF_MFS, 32'h7);
      irq(1'b0);
      rd(mefr_pkg::OFF_MFA, PA);
      fire(M_WR | M_RMW | M_PAR, IRQ, 1'b1);
      rd(mefr_pkg::OFF_MFS, 32'h1F);
      fire(M_DMA | M_PAR, ACK1 | IRQ, 1'b1);
      rd(mefr_pkg::OFF_MFA, PA);
      rd(mefr_pkg::OFF_MFS, 32'h3);
      fire(M_DMA | M_TMO, ACK1, 1'b1);
      fire(M_DMA | M_PTE, ACK1, 1'b1);
      fire(M_DMA | M_WR | M_RO, ACK1, 1'b1);
      // Size rides on the entry type lines; 1 tells the size bits apart
      g_e = 2'h1;
      fire(M_TMO | M_WR, IRQ, 1'b1);
      rd(mefr_pkg::OFF_AFA, PA);
      rd(mefr_pkg::OFF_AFS, 32'h63);
      irq(1'b0);
      fire(M_BERR | M_WR, IRQ, 1'b1);
      rd(mefr_pkg::OFF_AFS, 32'h69);
      fire(M_LATE, NONE, 1'b1);
      rd(mefr_pkg::OFF_AFS, 32'h75);
      fire(M_LATE | M_WR, NONE, 1'b1);
      rd(mefr_pkg::OFF_AFS, 32'h65);
      g_k = 3'h6;
      fire(M_LATE | M_WR, NONE, 1'b1);
      rd(mefr_pkg::OFF_AFS, 32'h45);
      g_k = 3'h7;
      wr(mefr_pkg::OFF_CTL, 32'h0);
      fire(M_TMO | M_WR, NONE, 1'b1);
      wr(mefr_pkg::OFF_CTL, 32'h1);
      irq(1'b1);
      rd(mefr_pkg::OFF_AFS, 32'h63);
      irq(1'b0);
      results();
   end
endmodule : tb_memory_error_fault_reporter
`default_nettype wire
